// ===== spo_consts.vh
/*
  Constants for the first serial port: register indices, control bit
  positions, mode codes and bit-timing counts.
  Assumes it is included by its bare name from the serial port design files.
*/
`ifndef SPO_CONSTS_VH
`define SPO_CONSTS_VH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define SPO_IDX_CTRL 8'h98
`define SPO_IDX_BUF 8'h99
`define SPO_IDX_ROUTE 8'hA6
`define SPO_IDX_ISTAT 8'hB0
`define SPO_IDX_IMASK 8'hB1
`define SPO_IDX_ICTRL 8'hB2

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define SPO_RST_BYTE 8'h00
`define SPO_RST_WORD 32'h00000000

// ----------------------------------------------------------------------
// Serial control bit positions
// ----------------------------------------------------------------------
`define SPO_B_MODE_HI 7
`define SPO_B_MODE_LO 6
`define SPO_B_FILTER 5
`define SPO_B_REN 4
`define SPO_B_TX9 3
`define SPO_B_RX9 2
`define SPO_B_TXDONE 1
`define SPO_B_RXDONE 0

// Interrupt status and mask bits, interrupt control bits
`define SPO_IS_RX 0
`define SPO_IS_TX 1
`define SPO_IC_EN 0
`define SPO_IC_SLOW 1

// ----------------------------------------------------------------------
// Modes and timing
// ----------------------------------------------------------------------
`define SPO_MODE_SHIFT 2'b00
`define SPO_MODE_ASYNC8 2'b01
`define SPO_MODE_ASYNC9F 2'b10
`define SPO_MODE_ASYNC9V 2'b11
// Sixteen oversample ticks per bit, sampled at the middle one
`define SPO_OS_LAST 4'hF
`define SPO_OS_MID 4'h7
// Clocks per tick in the fixed 9-bit mode: /32 -> 2, /64 -> 4
`define SPO_DIV_FAST 2'h1
`define SPO_DIV_SLOW 2'h3
// Last bit index of a frame (start, data, [ninth], stop)
`define SPO_LAST8 4'h9
`define SPO_LAST9 4'hA
`define SPO_NINTH_IDX 4'h9
`define SPO_M0_LAST 3'h7
// Transmit bit index while a written byte waits for the next tick
`define SPO_TX_WAIT 4'hF
// Route field: bit 0 picks pin pair, bit 1 swaps receive and transmit
`define SPO_RT_PAIR 0
`define SPO_RT_SWAP 1

`endif

// ===== spo_baud_gen.v
/*
  Oversample tick source for the asynchronous modes of the serial port.
  Assumes the external baud tick is one clock wide and synchronous.
*/
`include "spo_consts.vh"

module spo_baud_gen (
  input wire ref_clk_in,
  input wire rst_in,
  input wire [1:0] mode_in,
  input wire slow_in,
  input wire ext_tick_in,
  output reg os_tick_out
);

  reg [1:0] div_ff;
  wire [1:0] div_last;

  assign div_last = slow_in ? `SPO_DIV_SLOW : `SPO_DIV_FAST;

  // Fixed mode divides the system clock; others follow the timer tick
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      div_ff <= 2'h0;
      os_tick_out <= 1'b0;
    end else if (mode_in == `SPO_MODE_ASYNC9F) begin
      os_tick_out <= (div_ff == div_last);
      div_ff <= (div_ff == div_last) ? 2'h0 : div_ff + 2'h1;
    end else begin
      div_ff <= 2'h0;
      os_tick_out <= ext_tick_in;
    end
  end

endmodule // spo_baud_gen

// ===== spo_serial_port.v
/*
  First serial port: shift-register mode and 8/9-bit asynchronous modes,
  Wishbone register slave, interrupt status/mask and pin routing.
  Assumes a classic Wishbone master on ref_clk_in, synchronous pin inputs,
  and a 16x baud tick from a timer for the variable-rate modes.
*/
// The Wishbone interface to the registers is this design's own decision.
`include "spo_consts.vh"

// Overview of operation
// - Mode 00 shifts eight bits synchronously at system clock over two.
// - Mode 01 is 8-bit asynchronous at the external variable baud.
// - Mode 10 is 9-bit asynchronous at clock over 32 or 64.
// - Mode 11 is 9-bit asynchronous at the external variable baud.
// - 9-bit modes with filter set drop frames whose ninth bit is 0.
// - 8-bit mode with filter set completes receive only on valid stop.
// - Reception happens only while the receive enable bit is 1.
// - 9-bit modes send the transmit ninth bit as the ninth data bit.
// - Received ninth bit, or stop bit in 8-bit unfiltered, loads flag.
// - Transmit done sets after eighth bit or at stop start; sticky.
// - Receive done sets after eighth bit or at stop sample; sticky.
// - Buffer writes feed the transmitter, reads return last received byte.
// - Route field picks one of two pin pairs, codes 1x swap them.
// - Interrupt reaches the processor only while its enable bit is 1.
module spo_serial_port (
  input wire ref_clk_in,
  input wire rst_in,
  input wire wb_cyc_in,
  input wire wb_stb_in,
  input wire wb_we_in,
  input wire [9:0] wb_adr_in,
  input wire [3:0] wb_sel_in,
  input wire [31:0] wb_dat_in,
  output reg [31:0] wb_dat_out,
  output reg wb_ack_out,
  input wire baud_tick_in,
  input wire [3:0] pin_in,
  output reg [3:0] pin_out,
  output reg [3:0] pin_oe_out,
  output wire irq_out
);

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  reg [7:0] ctrl_ff;
  reg [7:0] rx_buf_ff;
  reg [7:0] route_ff;
  reg [7:0] istat_ff;
  reg [7:0] imask_ff;
  reg [7:0] ictrl_ff;
  reg tx_evt_ff;
  reg rx_evt_ff;
  reg [7:0] rx_data_ff;
  reg rx9_val_ff;
  reg rx9_load_ff;

  wire [1:0] mode = {ctrl_ff[`SPO_B_MODE_HI], ctrl_ff[`SPO_B_MODE_LO]};
  wire is_shift = (mode == `SPO_MODE_SHIFT);
  wire is_nine = mode[1];
  wire ren = ctrl_ff[`SPO_B_REN];
  wire [3:0] last_idx = is_nine ? `SPO_LAST9 : `SPO_LAST8;

  // --------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------
  wire [7:0] idx = wb_adr_in[9:2];
  wire req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  wire wr_lo = req & wb_we_in & wb_sel_in[0];
  wire rd = req & ~wb_we_in;
  wire wr_buf = wr_lo & (idx == `SPO_IDX_BUF);
  wire rd_stat = rd & (idx == `SPO_IDX_ISTAT);

  // --------------------------------------------------------------------
  // Pin routing inputs
  // --------------------------------------------------------------------
  wire [1:0] pair_base = route_ff[`SPO_RT_PAIR] ? 2'h2 : 2'h0;
  wire [1:0] rx_pin = pair_base | {1'b0, route_ff[`SPO_RT_SWAP]};
  wire [1:0] tx_pin = pair_base | {1'b0, ~route_ff[`SPO_RT_SWAP]};
  wire rx_line = pin_in[rx_pin];

  wire os_tick;

  spo_baud_gen u_baud (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .mode_in(mode),
    .slow_in(ictrl_ff[`SPO_IC_SLOW]),
    .ext_tick_in(baud_tick_in),
    .os_tick_out(os_tick)
  );

  // --------------------------------------------------------------------
  // Asynchronous transmitter
  // --------------------------------------------------------------------
  reg tx_busy_ff;
  reg [3:0] tx_os_ff;
  reg [3:0] tx_idx_ff;
  reg [10:0] tx_sh_ff;
  reg tx_line_ff;
  reg tx_evt_a;
  wire tx_ninth = is_nine ? ctrl_ff[`SPO_B_TX9] : 1'b1;

  // Writes while busy are dropped: the frame in flight is never torn
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      tx_busy_ff <= 1'b0;
      tx_os_ff <= 4'h0;
      tx_idx_ff <= 4'h0;
      tx_sh_ff <= 11'h7FF;
      tx_line_ff <= 1'b1;
      tx_evt_a <= 1'b0;
    end else begin
      tx_evt_a <= 1'b0;
      if (is_shift) begin
        tx_busy_ff <= 1'b0;
        tx_line_ff <= 1'b1;
      end else if (!tx_busy_ff) begin
        if (wr_buf) begin
          tx_busy_ff <= 1'b1;
          tx_sh_ff <= {1'b1, tx_ninth, wb_dat_in[7:0], 1'b0};
          tx_line_ff <= 1'b1;
          tx_os_ff <= 4'h0;
          tx_idx_ff <= `SPO_TX_WAIT;
        end
      end else if (os_tick && tx_idx_ff == `SPO_TX_WAIT) begin
        // Start on a tick, else the start bit is short by a tick phase
        tx_line_ff <= 1'b0;
        tx_os_ff <= 4'h0;
        tx_idx_ff <= 4'h0;
      end else if (os_tick) begin
        tx_os_ff <= tx_os_ff + 4'h1;
        if (tx_os_ff == `SPO_OS_LAST) begin
          if (tx_idx_ff == last_idx) begin
            tx_busy_ff <= 1'b0;
            tx_line_ff <= 1'b1;
          end else begin
            tx_idx_ff <= tx_idx_ff + 4'h1;
            tx_sh_ff <= {1'b1, tx_sh_ff[10:1]};
            tx_line_ff <= tx_sh_ff[1];
            if (tx_idx_ff + 4'h1 == last_idx) begin
              tx_evt_a <= 1'b1;
            end
          end
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Asynchronous receiver
  // --------------------------------------------------------------------
  reg rx_busy_ff;
  reg rx_prev_ff;
  reg [3:0] rx_os_ff;
  reg [3:0] rx_idx_ff;
  reg [7:0] rx_sh_ff;
  reg rx_nin_ff;
  reg rx_evt_a;
  reg rx9_load_a;
  reg rx9_val_a;
  reg [7:0] rx_data_a;
  wire stop_ok = rx_line;
  wire filt = ctrl_ff[`SPO_B_FILTER];

  // Single mid-bit sample; a high start sample is a glitch and aborts
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rx_busy_ff <= 1'b0;
      rx_prev_ff <= 1'b1;
      rx_os_ff <= 4'h0;
      rx_idx_ff <= 4'h0;
      rx_sh_ff <= 8'h00;
      rx_nin_ff <= 1'b0;
      rx_evt_a <= 1'b0;
      rx9_load_a <= 1'b0;
      rx9_val_a <= 1'b0;
      rx_data_a <= 8'h00;
    end else begin
      rx_evt_a <= 1'b0;
      rx9_load_a <= 1'b0;
      rx_prev_ff <= rx_line;
      if (is_shift || !ren) begin
        rx_busy_ff <= 1'b0;
      end else if (!rx_busy_ff) begin
        if (rx_prev_ff && !rx_line) begin
          rx_busy_ff <= 1'b1;
          rx_os_ff <= 4'h0;
          rx_idx_ff <= 4'h0;
        end
      end else if (os_tick) begin
        rx_os_ff <= rx_os_ff + 4'h1;
        if (rx_os_ff == `SPO_OS_LAST) begin
          rx_idx_ff <= rx_idx_ff + 4'h1;
        end
        if (rx_os_ff == `SPO_OS_MID) begin
          if (rx_idx_ff == 4'h0) begin
            rx_busy_ff <= rx_line ? 1'b0 : 1'b1;
          end else if (rx_idx_ff == last_idx) begin
            rx_busy_ff <= 1'b0;
            rx_data_a <= rx_sh_ff;
            if (is_nine) begin
              rx_evt_a <= ~filt | rx_nin_ff;
              rx9_load_a <= ~filt | rx_nin_ff;
              rx9_val_a <= rx_nin_ff;
            end else begin
              rx_evt_a <= ~filt | stop_ok;
              rx9_load_a <= ~filt;
              rx9_val_a <= stop_ok;
            end
          end else if (rx_idx_ff == `SPO_NINTH_IDX) begin
            rx_nin_ff <= rx_line;
          end else begin
            rx_sh_ff <= {rx_line, rx_sh_ff[7:1]};
          end
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Shift-register mode engine
  // --------------------------------------------------------------------
  reg m0_busy_ff;
  reg m0_rx_ff;
  reg m0_phase_ff;
  reg [2:0] m0_cnt_ff;
  reg [7:0] m0_sh_ff;
  reg m0_tx_evt;
  reg m0_rx_evt;
  wire m0_rx_go = ren & ~ctrl_ff[`SPO_B_RXDONE] & ~rx_evt_ff;

  // One bit per two clocks: low phase drives data, high phase samples
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      m0_busy_ff <= 1'b0;
      m0_rx_ff <= 1'b0;
      m0_phase_ff <= 1'b0;
      m0_cnt_ff <= 3'h0;
      m0_sh_ff <= 8'h00;
      m0_tx_evt <= 1'b0;
      m0_rx_evt <= 1'b0;
    end else begin
      m0_tx_evt <= 1'b0;
      m0_rx_evt <= 1'b0;
      if (!is_shift) begin
        m0_busy_ff <= 1'b0;
      end else if (!m0_busy_ff) begin
        m0_phase_ff <= 1'b0;
        m0_cnt_ff <= 3'h0;
        if (wr_buf) begin
          m0_busy_ff <= 1'b1;
          m0_rx_ff <= 1'b0;
          m0_sh_ff <= wb_dat_in[7:0];
        end else if (m0_rx_go) begin
          m0_busy_ff <= 1'b1;
          m0_rx_ff <= 1'b1;
        end
      end else begin
        m0_phase_ff <= ~m0_phase_ff;
        if (m0_phase_ff) begin
          m0_sh_ff <= {m0_rx_ff ? rx_line : 1'b1, m0_sh_ff[7:1]};
          m0_cnt_ff <= m0_cnt_ff + 3'h1;
          if (m0_cnt_ff == `SPO_M0_LAST) begin
            m0_busy_ff <= 1'b0;
            m0_tx_evt <= ~m0_rx_ff;
            m0_rx_evt <= m0_rx_ff;
          end
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Event merge, registered one cycle ahead of the flags
  // --------------------------------------------------------------------
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      tx_evt_ff <= 1'b0;
      rx_evt_ff <= 1'b0;
      rx_data_ff <= 8'h00;
      rx9_val_ff <= 1'b0;
      rx9_load_ff <= 1'b0;
    end else begin
      tx_evt_ff <= tx_evt_a | m0_tx_evt;
      rx_evt_ff <= rx_evt_a | m0_rx_evt;
      rx_data_ff <= m0_rx_evt ? {rx_line, m0_sh_ff[7:1]} : rx_data_a;
      rx9_val_ff <= rx9_val_a;
      rx9_load_ff <= rx9_load_a;
    end
  end

  // --------------------------------------------------------------------
  // Register file; hardware set wins over a software clear
  // --------------------------------------------------------------------
  reg [7:0] nxt_ctrl;
  always @* begin
    nxt_ctrl = ctrl_ff;
    if (wr_lo && idx == `SPO_IDX_CTRL) begin
      nxt_ctrl = wb_dat_in[7:0];
    end
    if (rx9_load_ff) begin
      nxt_ctrl[`SPO_B_RX9] = rx9_val_ff;
    end
    if (tx_evt_ff) begin
      nxt_ctrl[`SPO_B_TXDONE] = 1'b1;
    end
    if (rx_evt_ff) begin
      nxt_ctrl[`SPO_B_RXDONE] = 1'b1;
    end
  end

  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_ff <= `SPO_RST_BYTE;
      rx_buf_ff <= `SPO_RST_BYTE;
      route_ff <= `SPO_RST_BYTE;
      istat_ff <= `SPO_RST_BYTE;
      imask_ff <= `SPO_RST_BYTE;
      ictrl_ff <= `SPO_RST_BYTE;
    end else begin
      ctrl_ff <= nxt_ctrl;
      if (rx_evt_ff) begin
        rx_buf_ff <= rx_data_ff;
      end
      if (wr_lo && idx == `SPO_IDX_ROUTE) begin
        route_ff <= wb_dat_in[7:0];
      end
      if (wr_lo && idx == `SPO_IDX_IMASK) begin
        imask_ff <= wb_dat_in[7:0];
      end
      if (wr_lo && idx == `SPO_IDX_ICTRL) begin
        ictrl_ff <= wb_dat_in[7:0];
      end
      // Read clears, but an event in the same cycle survives
      istat_ff <= (rd_stat ? 8'h00 : istat_ff) |
                  {6'h00, tx_evt_ff, rx_evt_ff};
    end
  end

  // Level interrupt gated by mask and the port enable
  assign irq_out = ictrl_ff[`SPO_IC_EN] & |(istat_ff & imask_ff);

  // --------------------------------------------------------------------
  // Wishbone answer: one wait state, unmapped reads return zero
  // --------------------------------------------------------------------
  reg [7:0] rd_byte;
  always @* begin
    case (idx)
      `SPO_IDX_CTRL: rd_byte = ctrl_ff;
      `SPO_IDX_BUF: rd_byte = rx_buf_ff;
      `SPO_IDX_ROUTE: rd_byte = route_ff;
      `SPO_IDX_ISTAT: rd_byte = istat_ff;
      `SPO_IDX_IMASK: rd_byte = imask_ff;
      `SPO_IDX_ICTRL: rd_byte = ictrl_ff;
      default: rd_byte = 8'h00;
    endcase
  end

  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= `SPO_RST_WORD;
    end else begin
      wb_ack_out <= req;
      if (rd) begin
        wb_dat_out <= {24'h000000, rd_byte};
      end
    end
  end

  // --------------------------------------------------------------------
  // Pin drivers
  // --------------------------------------------------------------------
  // Shift mode: data on the receive pin, shift clock on the transmit pin
  wire m0_drive = is_shift & m0_busy_ff & ~m0_rx_ff;
  wire tx_val = is_shift ? (~m0_busy_ff | m0_phase_ff) : tx_line_ff;
  wire rx_val = m0_sh_ff[0];

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_pin
      always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
          pin_out[gi] <= 1'b1;
          pin_oe_out[gi] <= 1'b0;
        end else if (tx_pin == gi) begin
          pin_out[gi] <= tx_val;
          pin_oe_out[gi] <= 1'b1;
        end else if (rx_pin == gi) begin
          pin_out[gi] <= rx_val;
          pin_oe_out[gi] <= m0_drive;
        end else begin
          pin_out[gi] <= 1'b1;
          pin_oe_out[gi] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule // spo_serial_port

// ===== spo_port_asserts.sv
/*
  Checker for the first serial port, watching only its top-level ports.
  Assumes a bind from the bench and a single clock domain.
*/
module spo_port_asserts (
  input wire ref_clk_in,
  input wire rst_in,
  input wire wb_cyc_in,
  input wire wb_stb_in,
  input wire wb_we_in,
  input wire [9:0] wb_adr_in,
  input wire [3:0] wb_sel_in,
  input wire [31:0] wb_dat_in,
  input wire [31:0] wb_dat_out,
  input wire wb_ack_out,
  input wire [3:0] pin_out,
  input wire [3:0] pin_oe_out,
  input wire irq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // Register shadows
  // ----
  logic [1:0] mode_ff;
  logic [1:0] rt_ff;
  logic ie_ff;
  logic slow_ff;
  logic [7:0] lo_ff;
  wire [7:0] idx = wb_adr_in[9:2];
  wire req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  wire wr = req & wb_we_in & wb_sel_in[0];
  wire unm = !(idx inside {8'h98, 8'h99, 8'hA6, 8'hB0, 8'hB1, 8'hB2});
  wire [1:0] rxi = {rt_ff[0], rt_ff[1]};
  wire txp = pin_out[rxi ^ 2'h1];
  // Snoop writes; count low run on the transmit pin
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      mode_ff <= 2'h0;
      rt_ff <= 2'h0;
      ie_ff <= 1'b0;
      slow_ff <= 1'b0;
      lo_ff <= 8'h00;
    end else begin
      lo_ff <= txp ? 8'h00 : lo_ff + 8'h01;
      if (wr && idx == 8'h98) mode_ff <= wb_dat_in[7:6];
      if (wr && idx == 8'hA6) rt_ff <= wb_dat_in[1:0];
      if (wr && idx == 8'hB2) ie_ff <= wb_dat_in[0];
      if (wr && idx == 8'hB2) slow_ff <= wb_dat_in[1];
    end
  end
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  property p_ack_lat; req |=> wb_ack_out; endproperty
  a_ack_lat: assert property (p_ack_lat) else $error("ack late");
  property p_ack_pulse; wb_ack_out |=> !wb_ack_out; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_unm; req && !wb_we_in && unm |=> wb_dat_out == 32'h0;
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  property p_dat_hold; $changed(wb_dat_out) |-> wb_ack_out; endproperty
  a_dat_hold: assert property (p_dat_hold) else $error("read data moved");
  property p_irq_gate; !ie_ff |-> !irq_out; endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("irq while disabled");
  // Low runs inside a frame are whole bit times
  property p_bit_time;
    $rose(txp) && mode_ff != 2'h0 |->
      lo_ff % ((mode_ff == 2'h2 && slow_ff) ? 8'h40 : 8'h20) == 8'h00;
  endproperty
  a_bit_time: assert property (p_bit_time)
    else $error("bit time wrong");
  property p_shift_clk; $rose(txp) && mode_ff == 2'h0 |-> lo_ff == 8'h01;
  endproperty
  a_shift_clk: assert property (p_shift_clk)
    else $error("shift clock low phase wrong");
  property p_tx_oe;
    mode_ff != 2'h0 && $stable(mode_ff) && $stable(rt_ff)
      |-> pin_oe_out[rxi ^ 2'h1] && !pin_oe_out[rxi];
  endproperty
  a_tx_oe: assert property (p_tx_oe)
    else $error("routed pin drive wrong");
endmodule // spo_port_asserts

// ===== spo_remote_uart.sv
/*
  Remote serial device: sends and captures whole frames on two lines.
  Assumes the bench calls its tasks just after a rising clock edge.
*/
module spo_remote_uart (
  input wire clk_in,
  input wire line_in,
  output logic line_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle high, as a pulled-up line
  initial line_out = 1'b1;
  // Start, nb bits LSB first, stop level st, then one idle bit
  task automatic send(input logic [8:0] d, input int nb, bt,
                      input logic st);
    line_out <= 1'b0;
    repeat (bt) @(posedge clk_in);
    for (int i = 0; i < nb; i++) begin
      line_out <= d[i];
      repeat (bt) @(posedge clk_in);
    end
    line_out <= st;
    repeat (bt) @(posedge clk_in);
    line_out <= 1'b1;
    repeat (bt) @(posedge clk_in);
  endtask
  // Mid-bit sampling from the start edge
  task automatic recv(input int nb, bt, output logic [8:0] d,
                      output logic st);
    d = 9'h000;
    do @(posedge clk_in); while (line_in !== 1'b0);
    repeat (bt / 2) @(posedge clk_in);
    for (int i = 0; i < nb; i++) begin
      repeat (bt) @(posedge clk_in);
      d[i] = line_in;
    end
    repeat (bt) @(posedge clk_in);
    st = line_in;
  endtask
endmodule // spo_remote_uart

// ===== testbench.sv
/*
  Self-checking bench for the first serial port.
  Assumes the checker and remote model are compiled first.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic wb_cyc_in = 1'b0;
  logic wb_stb_in = 1'b0;
  logic wb_we_in = 1'b0;
  logic [9:0] wb_adr_in = 10'h000;
  logic [3:0] wb_sel_in = 4'h0;
  logic [31:0] wb_dat_in = 32'h0;
  logic baud_tick_in = 1'b0;
  logic [31:0] wb_dat_out;
  logic wb_ack_out, irq_out, rem_line;
  logic [3:0] pin_in, pin_out, pin_oe_out;
  logic [1:0] rt = 2'h0;
  wire [1:0] rxi = {rt[0], rt[1]};
  wire [1:0] txi = rxi ^ 2'h1;
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;
  // ----
  // Clock, timer tick, pins
  // ----
  always #2 ref_clk_in = ~ref_clk_in;
  // Tick every other clock gives 32 clocks a bit
  always @(posedge ref_clk_in) baud_tick_in <= ~baud_tick_in;
  always_comb begin
    pin_in = 4'hF;
    pin_in[rxi] = rem_line;
  end
  spo_serial_port dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
    .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
    .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
    .baud_tick_in(baud_tick_in), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_out(pin_oe_out), .irq_out(irq_out));
  spo_remote_uart rem (.clk_in(ref_clk_in), .line_in(pin_out[txi]),
    .line_out(rem_line));
  // ----
  // Shared tasks
  // ----
  task automatic final_report;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Hang guard; a run needs well under this
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      final_report;
    end
  end
  task automatic chk(input logic [31:0] got, exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // Classic cycle: hold until ack is sampled, then release
  task automatic wb(input logic we, input logic [7:0] i, d,
                    output logic [31:0] q);
    @(posedge ref_clk_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in <= we;
    wb_adr_in <= {i, 2'b00};
    wb_sel_in <= 4'h1;
    wb_dat_in <= {24'h0, d};
    do @(posedge ref_clk_in); while (wb_ack_out !== 1'b1);
    q = wb_dat_out;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] i, d);
    logic [31:0] q;
    wb(1'b1, i, d, q);
  endtask
  task automatic rd(input logic [7:0] i, output logic [31:0] q);
    wb(1'b0, i, 8'h00, q);
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_regs;
    logic [31:0] q;
    logic [7:0] ix [6] = '{8'h98, 8'hA6, 8'hB0, 8'hB1, 8'hB2, 8'h40};
    foreach (ix[i]) begin
      rd(ix[i], q);
      chk(q, 32'h0);
    end
    wr(8'h40, 8'h5A);
    rd(8'h40, q);
    chk(q, 32'h0);
    wr(8'hA6, 8'hF0);
    rd(8'hA6, q);
    chk(q, 32'hF0);
    $display("regs test done");
  endtask
  // Modes 01, 10 at both rates, and 11, each on its own route: send one frame, take one frame
  task automatic t_frames;
    logic [31:0] q;
    logic [8:0] d;
    logic s;
    logic [1:0] md [4] = '{2'h1, 2'h2, 2'h2, 2'h3};
    int nb, bt;
    for (int k = 0; k < 4; k++) begin
      nb = (md[k] == 2'h1) ? 8 : 9;
      bt = (k == 2) ? 64 : 32;
      rt <= k[1:0];
      wr(8'hA6, {6'h0, k[1:0]});
      wr(8'hB2, {6'h0, k == 2, 1'b0});
      wr(8'h98, {md[k], 6'h18});
      fork
        wr(8'h99, 8'hA5);
        rem.recv(nb, bt, d, s);
      join
      chk(d, nb == 9 ? 9'h1A5 : 9'h0A5);
      chk(s, 1'b1);
      rem.send({k[0], 4'h3, k[3:0]}, nb, bt, 1'b1);
      rd(8'h98, q);
      chk(q, {24'h0, md[k], 3'b011, k[0] | (nb == 8), 2'b11});
      rd(8'h99, q);
      chk(q, {28'h3, k[3:0]});
      rd(8'hB0, q);
      chk(q, 32'h3);
      rd(8'hB0, q);
      chk(q, 32'h0);
      wr(8'h98, 8'h00);
    end
    $display("frames test done");
  endtask
  task automatic t_filter;
    logic [31:0] q;
    rt <= 2'h0;
    wr(8'hA6, 8'h00);
    wr(8'hB2, 8'h00);
    wr(8'h98, 8'hB0);
    rem.send(9'h011, 9, 32, 1'b1);
    rd(8'h98, q);
    chk(q, 32'hB0);
    rem.send(9'h122, 9, 32, 1'b1);
    rd(8'h98, q);
    chk(q, 32'hB5);
    rd(8'h99, q);
    chk(q, 32'h22);
    wr(8'h98, 8'h70);
    rem.send(9'h044, 8, 32, 1'b0);
    rd(8'h98, q);
    chk(q, 32'h70);
    rem.send(9'h055, 8, 32, 1'b1);
    rd(8'h98, q);
    chk(q, 32'h71);
    $display("filter test done");
  endtask
  task automatic t_ren;
    logic [31:0] q;
    wr(8'h98, 8'h80);
    rem.send(9'h177, 9, 32, 1'b1);
    rd(8'h98, q);
    chk(q, 32'h80);
    rd(8'h99, q);
    chk(q, 32'h55);
    $display("enable test done");
  endtask
  task automatic t_irq;
    logic [31:0] q;
    rd(8'hB0, q);
    wr(8'hB1, 8'h01);
    wr(8'h98, 8'h90);
    rem.send(9'h166, 9, 32, 1'b1);
    chk(irq_out, 1'b0);
    wr(8'hB2, 8'h01);
    chk(irq_out, 1'b1);
    wr(8'hB1, 8'h00);
    chk(irq_out, 1'b0);
    wr(8'hB1, 8'h01);
    chk(irq_out, 1'b1);
    rd(8'hB0, q);
    chk(q, 32'h1);
    chk(irq_out, 1'b0);
    wr(8'hB2, 8'h00);
    $display("irq test done");
  endtask
  // Shift mode: data on receive pin while the clock pin is low
  task automatic t_shift;
    logic [7:0] b;
    logic [31:0] q;
    wr(8'h98, 8'h00);
    fork
      wr(8'h99, 8'h96);
      for (int i = 0; i < 8; i++) begin
        do @(posedge ref_clk_in); while (pin_out[txi] !== 1'b0);
        b[i] = pin_out[rxi];
        do @(posedge ref_clk_in); while (pin_out[txi] !== 1'b1);
      end
    join
    chk(b, 8'h96);
    rd(8'h98, q);
    chk(q, 32'h02);
    $display("shift test done");
  endtask
  initial begin
    repeat (2) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    t_regs;
    t_frames;
    t_filter;
    t_ren;
    t_irq;
    t_shift;
    final_report;
  end
endmodule // testbench
bind spo_serial_port spo_port_asserts chk_i (.ref_clk_in(ref_clk_in),
  .rst_in(rst_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
  .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in),
  .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
  .wb_ack_out(wb_ack_out), .pin_out(pin_out), .pin_oe_out(pin_oe_out),
  .irq_out(irq_out));
